// ---- hw/pdc_top.sv ----
// What this block does
// (R1) Channel register bit 2 powers down channel A.
// (R2) Channel register bit 1 powers down channel B.
// (R3) Channel register bit 0 requests masked global power-down.
// (R4) Output register bit 5 powers down frame clock.
// (R5) Output register bit 4 powers down bit clock.
// (R6) Output bit 3 alone powers down lane A1.
// (R7) Output bit 2 powers down lane A0.
// (R8) Output bit 1 alone powers down lane B1.
// (R9) Output bit 0 alone powers down lane B0.
// (R10) Mask fields at bits 3..1, others written zero.
// (R11) Mask bit 3 keeps sample clock buffer on.
// (R12) Mask bit 2 keeps reference amplifier on.
// (R13) Mask bit 1 puts bandgap to sleep.
// (R14) Sleep pin enters global power-down while sync register bit 7 is clear.
// (R15) Channel and output blocks: own bit OR global; the other blocks: masked global only.
`timescale 1ns/1ns

module pdc_top (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic             sen_n_i,
    input  wire logic             sclk_i,
    input  wire logic             sdi_i,
    input  wire logic             sync_or_sleep_pin_i,
    output logic                  sdo_o,
    output logic                  sdo_oe_o,
    output logic                  global_sleep_o,
    output pdc_pkg::pdc_pd_t      pd_o
);

    // ==========================================================
    // Pin synchronisers.
    logic sen_n_s;
    logic sclk_s;
    logic sdi_s;
    logic pin_s;

    pdc_sync3 #(
        .RST_VAL (1'b1)
    ) u_sync_sen (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .in_i    (sen_n_i),
        .out_o   (sen_n_s)
    );

    pdc_sync3 #(
        .RST_VAL (1'b0)
    ) u_sync_sclk (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .in_i    (sclk_i),
        .out_o   (sclk_s)
    );

    pdc_sync3 #(
        .RST_VAL (1'b0)
    ) u_sync_sdi (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .in_i    (sdi_i),
        .out_o   (sdi_s)
    );

    pdc_sync3 #(
        .RST_VAL (1'b0)
    ) u_sync_pin (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .in_i    (sync_or_sleep_pin_i),
        .out_o   (pin_s)
    );

    // ==========================================================
    // Serial control slave.
    logic [6:0]       raddr;
    logic [7:0]       rdata;
    pdc_pkg::pdc_wr_t wr;

    pdc_spi u_spi (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .sen_n_i  (sen_n_s),
        .sclk_i   (sclk_s),
        .sdi_i    (sdi_s),
        .rdata_i  (rdata),
        .raddr_o  (raddr),
        .wr_o     (wr),
        .sdo_o    (sdo_o),
        .sdo_oe_o (sdo_oe_o)
    );

    // ==========================================================
    // Register file.
    logic [7:0] chan_r;
    logic [7:0] outbuf_r;
    logic [7:0] mask_r;
    logic [7:0] sync_r;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            chan_r   <= pdc_pkg::PDC_CHAN_RST;
            outbuf_r <= pdc_pkg::PDC_OUTBUF_RST;
            mask_r   <= pdc_pkg::PDC_MASK_RST;
            sync_r   <= pdc_pkg::PDC_SYNC_RST;
        end else if (wr.wr) begin
            unique case (wr.addr)
                pdc_pkg::PDC_ADDR_CHAN: begin
                    chan_r <= wr.data & pdc_pkg::PDC_CHAN_USED;
                end
                pdc_pkg::PDC_ADDR_OUTBUF: begin
                    outbuf_r <= wr.data & pdc_pkg::PDC_OUTBUF_USED;
                end
                pdc_pkg::PDC_ADDR_MASK: begin
                    mask_r <= wr.data & pdc_pkg::PDC_MASK_USED; // R10
                end
                pdc_pkg::PDC_ADDR_SYNC: begin
                    sync_r <= wr.data & pdc_pkg::PDC_SYNC_USED;
                end
                default: begin
                end
            endcase
        end
    end

    // Unmapped addresses read as zero.
    always_comb begin
        unique case (raddr)
            pdc_pkg::PDC_ADDR_CHAN:   rdata = chan_r;
            pdc_pkg::PDC_ADDR_OUTBUF: rdata = outbuf_r;
            pdc_pkg::PDC_ADDR_MASK:   rdata = mask_r;
            pdc_pkg::PDC_ADDR_SYNC:   rdata = sync_r;
            default:                  rdata = pdc_pkg::PDC_UNMAPPED_RD;
        endcase
    end

    // ==========================================================
    // Power-down decode.
    logic             glob_nxt;
    pdc_pkg::pdc_pd_t pd_nxt;

    always_comb begin
        glob_nxt = chan_r[pdc_pkg::PDC_GLOBAL_BIT] // R3
                 | (pin_s & ~sync_r[pdc_pkg::PDC_SYNC_PIN_BIT]); // R14
        pd_nxt.chan_a          = chan_r[pdc_pkg::PDC_CHAN_A_BIT] | glob_nxt; // R1
        pd_nxt.chan_b          = chan_r[pdc_pkg::PDC_CHAN_B_BIT] | glob_nxt; // R2
        pd_nxt.frame_clock_buf = outbuf_r[pdc_pkg::PDC_FRAME_BUF_BIT] | glob_nxt; // R4
        pd_nxt.bit_clock_buf   = outbuf_r[pdc_pkg::PDC_BIT_BUF_BIT] | glob_nxt; // R5
        pd_nxt.lane_a1         = outbuf_r[pdc_pkg::PDC_LANE_A1_BIT] | glob_nxt; // R6
        pd_nxt.lane_a0         = outbuf_r[pdc_pkg::PDC_LANE_A0_BIT] | glob_nxt; // R7
        pd_nxt.lane_b1         = outbuf_r[pdc_pkg::PDC_LANE_B1_BIT] | glob_nxt; // R8
        pd_nxt.lane_b0         = outbuf_r[pdc_pkg::PDC_LANE_B0_BIT] | glob_nxt; // R9
        pd_nxt.sample_clock_buf = glob_nxt & ~mask_r[pdc_pkg::PDC_KEEP_CLK_BIT]; // R11
        pd_nxt.reference_amp    = glob_nxt & ~mask_r[pdc_pkg::PDC_KEEP_REF_BIT]; // R12
        pd_nxt.bandgap          = glob_nxt & mask_r[pdc_pkg::PDC_BG_SEL_BIT]; // R13
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            global_sleep_o <= 1'b0;
            pd_o           <= '0;
        end else begin
            global_sleep_o <= glob_nxt;
            pd_o           <= pd_nxt; // R15
        end
    end

endmodule : pdc_top

// ---- hw/pdc_pkg.sv ----
package pdc_pkg;

    // ==========================================================
    // Register offsets on the serial control interface.
    localparam logic [6:0] PDC_ADDR_CHAN   = 7'h08;
    localparam logic [6:0] PDC_ADDR_OUTBUF = 7'h09;
    localparam logic [6:0] PDC_ADDR_MASK   = 7'h0D;
    localparam logic [6:0] PDC_ADDR_SYNC   = 7'h0E;

    // ==========================================================
    // Field positions.
    localparam int PDC_CHAN_A_BIT    = 2;
    localparam int PDC_CHAN_B_BIT    = 1;
    localparam int PDC_GLOBAL_BIT    = 0;
    localparam int PDC_FRAME_BUF_BIT = 5;
    localparam int PDC_BIT_BUF_BIT   = 4;
    localparam int PDC_LANE_A1_BIT   = 3;
    localparam int PDC_LANE_A0_BIT   = 2;
    localparam int PDC_LANE_B1_BIT   = 1;
    localparam int PDC_LANE_B0_BIT   = 0;
    localparam int PDC_KEEP_CLK_BIT  = 3;
    localparam int PDC_KEEP_REF_BIT  = 2;
    localparam int PDC_BG_SEL_BIT    = 1;
    localparam int PDC_SYNC_PIN_BIT  = 7;

    // Bits that hold state in each register; the rest read as zero.
    localparam logic [7:0] PDC_CHAN_USED   = 8'h07;
    localparam logic [7:0] PDC_OUTBUF_USED = 8'h3F;
    localparam logic [7:0] PDC_MASK_USED   = 8'h0E;
    localparam logic [7:0] PDC_SYNC_USED   = 8'h80;

    // ==========================================================
    // Values after reset.
    localparam logic [7:0] PDC_CHAN_RST    = 8'h00;
    localparam logic [7:0] PDC_OUTBUF_RST  = 8'h00;
    localparam logic [7:0] PDC_MASK_RST    = 8'h00;
    localparam logic [7:0] PDC_SYNC_RST    = 8'h00;
    localparam logic [7:0] PDC_UNMAPPED_RD = 8'h00;

    // ==========================================================
    // Serial frame: read flag, 7 address bits, 8 data bits, MSB first.
    localparam logic [4:0] PDC_HDR_BITS   = 5'h08;
    localparam logic [4:0] PDC_FRAME_BITS = 5'h10;

    // ==========================================================
    // Types.
    typedef enum logic [1:0] {
        PDC_IDLE = 2'h0,
        PDC_HDR  = 2'h1,
        PDC_DATA = 2'h3
    } pdc_spi_state_t;

    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [7:0] data;
    } pdc_wr_t;

    typedef struct packed {
        logic chan_a;
        logic chan_b;
        logic frame_clock_buf;
        logic bit_clock_buf;
        logic lane_a1;
        logic lane_a0;
        logic lane_b1;
        logic lane_b0;
        logic sample_clock_buf;
        logic reference_amp;
        logic bandgap;
    } pdc_pd_t;

endpackage : pdc_pkg

// ---- hw/pdc_sync3.sv ----
`timescale 1ns/1ns

// ==========================================================
// Three-stage pin synchroniser; a change counts once stages two and three agree.
module pdc_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic in_i,
    output logic      out_o
);

    logic meta_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_r <= RST_VAL;
            s2_r   <= RST_VAL;
            s3_r   <= RST_VAL;
        end else begin
            meta_r <= in_i;
            s2_r   <= meta_r;
            s3_r   <= s2_r;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            out_o <= RST_VAL;
        end else if (s2_r == s3_r) begin
            out_o <= s3_r;
        end
    end

endmodule : pdc_sync3

// ---- hw/pdc_spi.sv ----
`timescale 1ns/1ns

// ==========================================================
// Serial control slave working on synchronised pin levels.
module pdc_spi (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic             sen_n_i,
    input  wire logic             sclk_i,
    input  wire logic             sdi_i,
    input  wire logic [7:0]       rdata_i,
    output logic [6:0]            raddr_o,
    output pdc_pkg::pdc_wr_t      wr_o,
    output logic                  sdo_o,
    output logic                  sdo_oe_o
);

    pdc_pkg::pdc_spi_state_t state_r;
    logic                    sclk_d_r;
    logic [4:0]              cnt_r;
    logic [14:0]             shift_r;
    logic [7:0]              tx_r;
    logic                    rd_r;
    logic                    rise;
    logic                    fall;

    assign rise    = sclk_i & ~sclk_d_r;
    assign fall    = ~sclk_i & sclk_d_r;
    assign raddr_o = shift_r[6:0];

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_i;
        end
    end

    // Frame sequencing; a frame cut short by chip select is dropped.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= pdc_pkg::PDC_IDLE;
            cnt_r   <= 5'h00;
            shift_r <= 15'h0000;
            rd_r    <= 1'b0;
            tx_r    <= 8'h00;
            wr_o    <= '0;
        end else begin
            wr_o.wr <= 1'b0;
            if (sen_n_i) begin
                state_r <= pdc_pkg::PDC_IDLE;
                cnt_r   <= 5'h00;
            end else begin
                unique case (state_r)
                    pdc_pkg::PDC_IDLE: begin
                        state_r <= pdc_pkg::PDC_HDR;
                        cnt_r   <= 5'h00;
                    end
                    pdc_pkg::PDC_HDR: begin
                        if (rise) begin
                            shift_r <= {shift_r[13:0], sdi_i};
                            cnt_r   <= cnt_r + 5'h01;
                            if (cnt_r + 5'h01 == pdc_pkg::PDC_HDR_BITS) begin
                                state_r <= pdc_pkg::PDC_DATA;
                                rd_r    <= shift_r[6];
                            end
                        end
                    end
                    pdc_pkg::PDC_DATA: begin
                        if (cnt_r == pdc_pkg::PDC_HDR_BITS && !rise && !fall) begin
                            tx_r <= rdata_i;
                        end
                        if (fall && cnt_r != pdc_pkg::PDC_HDR_BITS) begin
                            tx_r <= {tx_r[6:0], 1'b0};
                        end
                        if (rise) begin
                            shift_r <= {shift_r[13:0], sdi_i};
                            cnt_r   <= cnt_r + 5'h01;
                            if (cnt_r + 5'h01 == pdc_pkg::PDC_FRAME_BITS) begin
                                state_r      <= pdc_pkg::PDC_IDLE;
                                wr_o.wr      <= ~rd_r;
                                wr_o.addr    <= shift_r[13:7];
                                wr_o.data    <= {shift_r[6:0], sdi_i};
                            end
                        end
                    end
                    default: begin
                        state_r <= pdc_pkg::PDC_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sdo_o    <= 1'b0;
            sdo_oe_o <= 1'b0;
        end else begin
            sdo_o    <= tx_r[7];
            sdo_oe_o <= ~sen_n_i & rd_r & (state_r == pdc_pkg::PDC_DATA);
        end
    end

endmodule : pdc_spi

// ---- tb/pdc_top_properties.sv ----
`timescale 1ns/1ns

// ==========================================================
// Power-down and serial output checks.
module pdc_top_properties (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic             sen_n_i,
    input  wire logic             sclk_i,
    input  wire logic             sdi_i,
    input  wire logic             sync_or_sleep_pin_i,
    input  wire logic             sdo_o,
    input  wire logic             sdo_oe_o,
    input  wire logic             global_sleep_o,
    input  wire pdc_pkg::pdc_pd_t pd_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    AST_GLOBAL_CLOCKS: assert property (global_sleep_o |-> &pd_o[10:7])
        else $error("global sleep left a channel or clock buffer on");
    AST_GLOBAL_LANES: assert property (global_sleep_o |-> &pd_o[6:3])
        else $error("global sleep left a lane buffer on");
    AST_CLKBUF: assert property (pd_o.sample_clock_buf |-> global_sleep_o)
        else $error("sample clock buffer off without global sleep");
    AST_REFAMP: assert property (pd_o.reference_amp |-> global_sleep_o)
        else $error("reference amplifier off without global sleep");
    AST_BANDGAP: assert property (!global_sleep_o |-> !pd_o.bandgap)
        else $error("bandgap off without global sleep");
    AST_RESET_ZERO: assert property ($fell(reset_i) |-> pd_o == '0 && !global_sleep_o)
        else $error("outputs not zero after reset");
    AST_QUIET: assert property ((sen_n_i && $stable(sync_or_sleep_pin_i))[*8]
        |=> $stable(pd_o) && $stable(global_sleep_o))
        else $error("power-down outputs moved with no cause");
    AST_SDO_IDLE: assert property (sen_n_i[*8] |-> !sdo_oe_o)
        else $error("serial output driven while deselected");
endmodule : pdc_top_properties

bind pdc_top pdc_top_properties u_chk (
    .clk_i(clk_i), .reset_i(reset_i), .sen_n_i(sen_n_i), .sclk_i(sclk_i),
    .sdi_i(sdi_i), .sync_or_sleep_pin_i(sync_or_sleep_pin_i), .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o), .global_sleep_o(global_sleep_o), .pd_o(pd_o)
);

// ---- tb/tb.sv ----
`timescale 1ns/1ns

module tb;
    typedef struct packed {
        logic [6:0]  addr;
        logic [7:0]  data;
        logic [7:0]  rd;
        logic [10:0] pd;
        logic        gl;
    } pdc_row_t;

    logic             clk_i, reset_i, sen_n_i, sclk_i, sdi_i, pin;
    logic             sdo_o, sdo_oe_o, global_sleep_o;
    pdc_pkg::pdc_pd_t pd_o;
    logic [7:0]       q;
    logic             oe;
    int               errors = 0;
    int               comparisons = 0;

    // Rows: address, data written, readback, power-down vector, global.
    pdc_row_t rows [17] = '{
        '{7'h08, 8'h04, 8'h04, 11'h400, 1'b0},
        '{7'h08, 8'h02, 8'h02, 11'h200, 1'b0},
        '{7'h08, 8'hF8, 8'h00, 11'h000, 1'b0},
        '{7'h09, 8'h20, 8'h20, 11'h100, 1'b0},
        '{7'h09, 8'h10, 8'h10, 11'h080, 1'b0},
        '{7'h09, 8'h08, 8'h08, 11'h040, 1'b0},
        '{7'h09, 8'h04, 8'h04, 11'h020, 1'b0},
        '{7'h09, 8'h02, 8'h02, 11'h010, 1'b0},
        '{7'h09, 8'h01, 8'h01, 11'h008, 1'b0},
        '{7'h09, 8'hC0, 8'h00, 11'h000, 1'b0},
        '{7'h0D, 8'hF1, 8'h00, 11'h000, 1'b0},
        '{7'h08, 8'h01, 8'h01, 11'h7FE, 1'b1},
        '{7'h0D, 8'h0E, 8'h0E, 11'h7F9, 1'b1},
        '{7'h0D, 8'h08, 8'h08, 11'h7FA, 1'b1},
        '{7'h0D, 8'h02, 8'h02, 11'h7FF, 1'b1},
        '{7'h08, 8'h00, 8'h00, 11'h000, 1'b0},
        '{7'h15, 8'hFF, 8'h00, 11'h000, 1'b0}
    };

    pdc_top uut (
        .clk_i               (clk_i),
        .reset_i             (reset_i),
        .sen_n_i             (sen_n_i),
        .sclk_i              (sclk_i),
        .sdi_i               (sdi_i),
        .sync_or_sleep_pin_i (pin),
        .sdo_o               (sdo_o),
        .sdo_oe_o            (sdo_oe_o),
        .global_sleep_o      (global_sleep_o),
        .pd_o                (pd_o)
    );

    // ==========================================================
    // Tasks.
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    // Sends the first nbits of a frame; fewer than 16 aborts it.
    task automatic frame(input logic rd, input logic [6:0] addr, input logic [7:0] data,
                         input int nbits, output logic [7:0] d);
        logic [15:0] w;
        w = {rd, addr, data};
        d = 8'h00;
        oe = 1'b0;
        sen_n_i = 1'b0;
        repeat (6) @(negedge clk_i);
        for (int i = 15; i >= 16 - nbits; i--) begin
            sdi_i = w[i];
            repeat (6) @(negedge clk_i);
            if (i < 8) d = {d[6:0], sdo_o};
            if (i == 0) oe = sdo_oe_o;
            sclk_i = 1'b1;
            repeat (6) @(negedge clk_i);
            sclk_i = 1'b0;
        end
        repeat (6) @(negedge clk_i);
        sen_n_i = 1'b1;
        sdi_i = ~sdi_i;
        repeat (10) @(negedge clk_i);
    endtask : frame

    task automatic stop_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    // ==========================================================
    // Stimulus.
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    initial begin
        #2000000;
        errors++;
        stop_test();
    end

    initial begin
        reset_i = 1'b1;
        sen_n_i = 1'b1;
        sclk_i = 1'b0;
        sdi_i = 1'b0;
        pin = 1'b0;
        repeat (12) @(negedge clk_i);
        reset_i = 1'b0;
        repeat (6) @(negedge clk_i);
        foreach (rows[n]) begin
            frame(1'b0, rows[n].addr, rows[n].data, 16, q);
            check({5'h00, pd_o}, {5'h00, rows[n].pd});
            check({15'h0000, global_sleep_o}, {15'h0000, rows[n].gl});
            check({15'h0000, oe}, 16'h0000);
            frame(1'b1, rows[n].addr, 8'h00, 16, q);
            check({8'h00, q}, {8'h00, rows[n].rd});
            check({15'h0000, oe}, 16'h0001);
        end
        // The pin sleeps the device until the sync-pin enable takes it over.
        pin = 1'b1;
        repeat (12) @(negedge clk_i);
        check({5'h00, pd_o}, 16'h07FF);
        frame(1'b0, pdc_pkg::PDC_ADDR_SYNC, 8'h80, 16, q);
        check({4'h0, global_sleep_o, pd_o}, 16'h0000);
        pin = 1'b0;
        frame(1'b0, pdc_pkg::PDC_ADDR_SYNC, 8'h00, 16, q);
        frame(1'b0, pdc_pkg::PDC_ADDR_OUTBUF, 8'h3F, 12, q);
        check({5'h00, pd_o}, 16'h0000);
        frame(1'b0, pdc_pkg::PDC_ADDR_MASK, 8'h0E, 16, q);
        frame(1'b0, pdc_pkg::PDC_ADDR_OUTBUF, 8'h3F, 16, q);
        check({5'h00, pd_o}, 16'h01F8);
        reset_i = 1'b1;
        repeat (12) @(negedge clk_i);
        reset_i = 1'b0;
        repeat (6) @(negedge clk_i);
        check({5'h00, pd_o}, 16'h0000);
        frame(1'b1, pdc_pkg::PDC_ADDR_OUTBUF, 8'h00, 16, q);
        check({8'h00, q}, 16'h0000);
        frame(1'b1, pdc_pkg::PDC_ADDR_MASK, 8'h00, 16, q);
        check({8'h00, q}, 16'h0000);
        stop_test();
    end
endmodule : tb
